//--- bench/pm_ctrl_checker.sv
// Port checker for the power management sequencer.
// Assumes one bus clock; bound onto every pm_ctrl.
`timescale 1ns/1ns
module pm_ctrl_checker
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic handler_done,
   input wire logic snoop_req,
   input wire logic intr_req,
   input wire logic save_state,
   input wire logic sys_mgmt_mode,
   input wire logic smi_ack_cycle,
   input wire logic handler_fetch,
   input wire logic grant_ack_cycle,
   input wire logic core_clk_en,
   input wire logic bus_clk_en,
   input wire logic local_interrupt_ctrl_clk_en,
   input wire logic snoop_ack,
   input wire logic intr_ack,
   input wire logic outputs_tristate
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   sequence s_save;
      save_state [*4] ##1 (!save_state && sys_mgmt_mode);
   endsequence
   sequence s_enter;
      smi_ack_cycle && handler_fetch;
   endsequence
   AST_SAVE: assert property ($rose(save_state) |-> s_save)
      else $error("save sequence wrong");
   AST_ENTER: assert property ($rose(sys_mgmt_mode) |=> s_enter)
      else $error("no acknowledge after entry");
   AST_MODE: assert property (sys_mgmt_mode |=>
      sys_mgmt_mode == !$past(handler_done)) else $error("mode hold wrong");
   AST_GRANT: assert property (grant_ack_cycle |=>
      !core_clk_en && bus_clk_en && !grant_ack_cycle)
      else $error("grant clocks wrong");
   AST_SNOOP: assert property (snoop_req && !core_clk_en && bus_clk_en
      |=> snoop_ack) else $error("snoop not answered");
   AST_INTR: assert property (intr_req && !core_clk_en && bus_clk_en
      |=> intr_ack) else $error("interrupt not serviced");
   AST_QUIET: assert property (!bus_clk_en && !$past(bus_clk_en)
      |-> !snoop_ack && !intr_ack) else $error("sleep answered");
   AST_OUTSIDE: assert property (core_clk_en && $past(core_clk_en)
      |-> !snoop_ack && !intr_ack) else $error("ack outside grant");
   AST_TRIST: assert property (outputs_tristate |=> outputs_tristate)
      else $error("tristate dropped");
   AST_LIC: assert property (local_interrupt_ctrl_clk_en == bus_clk_en)
      else $error("interrupt unit clock differs from bus clock");
endmodule
bind pm_ctrl pm_ctrl_checker i_pm_ctrl_checker(.clock, .rst_n,
   .handler_done, .snoop_req, .intr_req, .save_state, .sys_mgmt_mode,
   .smi_ack_cycle, .handler_fetch, .grant_ack_cycle, .core_clk_en,
   .bus_clk_en, .local_interrupt_ctrl_clk_en, .snoop_ack, .intr_ack,
   .outputs_tristate);

//--- bench/pm_ctrl_tb_top.sv
// Testbench for the power management sequencer.
// Assumes the sideband model and the bound checker.
`timescale 1ns/1ns
module pm_ctrl_tb_top;
   logic clock, rst_n, handler_done, snoop_req, intr_req;
   logic want_irq, want_halt, want_sleep;
   logic sys_mgmt_irq_n, clock_halt_req_n, sleep_req_n;
   logic save_state, sys_mgmt_mode, smi_ack_cycle, handler_fetch;
   logic grant_ack_cycle, core_clk_en, bus_clk_en, lic_en;
   logic snoop_ack, intr_ack, outputs_tristate;
   int error_cnt = 0;
   int samples_checked = 0;
   sideband_model i_sideband_model(.want_irq, .want_halt, .want_sleep,
      .sys_mgmt_irq_n, .clock_halt_req_n, .sleep_req_n);
   pm_ctrl i_pm_ctrl(.clock, .rst_n, .sys_mgmt_irq_n, .clock_halt_req_n,
      .sleep_req_n, .handler_done, .snoop_req, .intr_req, .save_state,
      .sys_mgmt_mode, .smi_ack_cycle, .handler_fetch, .grant_ack_cycle,
      .core_clk_en, .bus_clk_en, .local_interrupt_ctrl_clk_en(lic_en),
      .snoop_ack, .intr_ack, .outputs_tristate);
   ////////////////////////////////////////////////////////////////////////
   task at(input int n);
      repeat (n) @(posedge clock);
   endtask
   task chk(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %b got %b", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_irq;
      want_irq <= 1;
      at(3); #1 chk("save", 1, save_state);
      at(4); #1 chk("mode", 1, sys_mgmt_mode);
      at(1); #1 chk("smi ack", 1, smi_ack_cycle);
      chk("fetch", 1, handler_fetch);
      at(1); want_irq <= 0; want_halt <= 1;
      at(6); #1 chk("halt in mode", 1, core_clk_en);
      at(1); want_halt <= 0;
      at(4); handler_done <= 1;
      at(1); handler_done <= 0;
      #1 chk("mode end", 0, sys_mgmt_mode);
      $display("test irq done");
   endtask
   task t_halt;
      at(4); want_halt <= 1;
      at(3); #1 chk("grant ack", 1, grant_ack_cycle);
      at(1); #1 chk("core en", 0, core_clk_en);
      chk("bus en", 1, bus_clk_en);
      chk("lic en", 1, lic_en);
      at(1); snoop_req <= 1;
      at(1); snoop_req <= 0; intr_req <= 1;
      #1 chk("snoop ack", 1, snoop_ack);
      at(1); intr_req <= 0; want_sleep <= 1;
      #1 chk("intr ack", 1, intr_ack);
      at(3); #1 chk("sleep bus", 0, bus_clk_en);
      at(1); snoop_req <= 1;
      at(2); snoop_req <= 0; want_sleep <= 0;
      #1 chk("sleep snoop", 0, snoop_ack);
      at(3); #1 chk("wake bus", 1, bus_clk_en);
      at(1); want_halt <= 0;
      at(3); #1 chk("resume", 1, core_clk_en);
      $display("test halt done");
   endtask
   task t_trist;
      at(1); want_irq <= 1; rst_n <= 0;
      at(20); rst_n <= 1;
      at(2); #1 chk("tristate", 1, outputs_tristate);
      at(1); want_irq <= 0; rst_n <= 0;
      at(20); rst_n <= 1;
      at(2); #1 chk("clear", 0, outputs_tristate);
      chk("normal", 1, core_clk_en);
      $display("test tristate done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      #(2000 * 50);
      error_cnt++;
      give_verdict;
   end
   initial
   begin
      {rst_n, handler_done, snoop_req, intr_req} = 4'h0;
      {want_irq, want_halt, want_sleep} = 3'h0;
      at(20); rst_n <= 1;
      at(2);
      t_irq;
      t_halt;
      t_trist;
      give_verdict;
   end
endmodule

//--- bench/sideband_model.sv
// Chipset side: drives the three active low request pins.
// Assumes level commands from the bench; pins move off the clock edge.
`timescale 1ns/1ns
module sideband_model
(
   input wire logic want_irq,
   input wire logic want_halt,
   input wire logic want_sleep,
   output logic sys_mgmt_irq_n,
   output logic clock_halt_req_n,
   output logic sleep_req_n
);
   // Odd delay keeps pin changes unrelated to the clock
   assign #7 sys_mgmt_irq_n = ~want_irq;
   assign #7 clock_halt_req_n = ~want_halt;
   assign #7 sleep_req_n = ~want_sleep;
endmodule

//--- rtl/pm_ctrl.sv
// Sequencer for system management interrupt and clock halt requests.
// Assumes request pins are asynchronous; bus clock always running.
// How it works
// [R1] Interrupt request may arrive anytime, unrelated to clock.
// [R2] Accepted interrupt saves execution state, then enters management mode.
// [R3] After entry, issue acknowledge on bus, then run handler.
// [R4] Interrupt low at reset release tri-states all outputs; only outputs_tristate is raised, the other outputs stay driven.
// [R5] Clock halt request moves normal execution into grant state.
// [R6] Entering grant drives a grant acknowledge on the bus.
// [R7] Grant gates core clocks; bus and interrupt unit clocks stay on.
// [R8] Grant still answers snoops and services interrupts.
// [R9] Withdrawn halt request restores clocks and resumes execution.
// [R10] Halt request leaves bus clock untouched; treated as asynchronous.
// [R11] Sleep request in grant enters sleep; removal returns to grant.
// [R12] Sleep ignores snoops and interrupts; only reset or removal act.
// [R13] All three requests pass a two-flop synchroniser first.
// [R14] State machine normal, grant, sleep; reset returns to normal.
`timescale 1ns/1ns
`include "pm_ctrl_defines.svh"
module pm_ctrl
   import pm_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sys_mgmt_irq_n,
   input wire logic clock_halt_req_n,
   input wire logic sleep_req_n,
   input wire logic handler_done,
   input wire logic snoop_req,
   input wire logic intr_req,
   output logic save_state,
   output logic sys_mgmt_mode,
   output logic smi_ack_cycle,
   output logic handler_fetch,
   output logic grant_ack_cycle,
   output logic core_clk_en,
   output logic bus_clk_en,
   output logic local_interrupt_ctrl_clk_en,
   output logic snoop_ack,
   output logic intr_ack,
   output logic outputs_tristate
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      pm_state_t fsm_reg;
      logic [3:0] cnt_reg;
      logic in_reset_reg;
      logic tri_reg;
      logic save_reg;
      logic mode_reg;
      logic smi_ack_reg;
      logic fetch_reg;
      logic grant_ack_reg;
      logic core_en_reg;
      logic bus_en_reg;
      logic lic_en_reg;
      logic snoop_ack_reg;
      logic intr_ack_reg;
   } pm_st_t;
   pm_st_t s_reg;
   pm_st_t s_next;
   logic smi_n_sync;
   logic halt_n_sync;
   logic sleep_n_sync;
   ////////////////////////////////////////////////////////////////////////
   // Pins are not timed to clock, so nothing reads them raw
   // Syncs run through reset so the strap level is valid at release
   sync_bit smi_sync
   (
      .clock(clock),
      .async_in(sys_mgmt_irq_n),
      .sync_out(smi_n_sync)
   ); // [R1] [R13]
   sync_bit halt_sync
   (
      .clock(clock),
      .async_in(clock_halt_req_n),
      .sync_out(halt_n_sync)
   ); // [R10] [R13]
   sync_bit sleep_sync
   (
      .clock(clock),
      .async_in(sleep_req_n),
      .sync_out(sleep_n_sync)
   ); // [R13]
   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_next = s_reg;
      s_next.in_reset_reg = 1'h0;
      // Acknowledges drop each cycle; snoop and interrupt acks in grant follow their request level
      s_next.smi_ack_reg = 1'h0;
      s_next.grant_ack_reg = 1'h0;
      s_next.snoop_ack_reg = 1'h0;
      s_next.intr_ack_reg = 1'h0;
      // Strap caught on first edge after release; synchronised level
      if (s_reg.in_reset_reg)
      begin
         s_next.tri_reg = !smi_n_sync; // [R4]
      end
      case (s_reg.fsm_reg)
         st_normal:
         begin
            // Interrupt outranks halt; both pending handles smi first, except on the strap cycle after reset release
            if (!smi_n_sync && !s_reg.in_reset_reg)
            begin
               s_next.fsm_reg = st_save; // [R2]
               s_next.save_reg = 1'h1;
               s_next.cnt_reg = `SAVE_CYCLES;
            end
            // Sleep alone is ignored outside grant
            else if (!halt_n_sync)
            begin
               s_next.fsm_reg = st_grant_ack; // [R5]
               s_next.grant_ack_reg = 1'h1; // [R6]
            end
         end
         st_save:
         begin
            // Fixed length, so the handler never sees a half save
            s_next.cnt_reg = s_reg.cnt_reg - 4'h1;
            if (s_reg.cnt_reg == 4'h1)
            begin
               s_next.save_reg = 1'h0;
               s_next.mode_reg = 1'h1; // [R2]
               s_next.fsm_reg = st_smm_ack;
            end
         end
         st_smm_ack:
         begin
            s_next.smi_ack_reg = 1'h1; // [R3]
            s_next.fetch_reg = 1'h1; // [R3]
            s_next.fsm_reg = st_smm_run;
         end
         st_smm_run:
         begin
            // Halt waits here until the handler is done
            if (handler_done)
            begin
               s_next.fetch_reg = 1'h0;
               s_next.mode_reg = 1'h0;
               s_next.fsm_reg = st_normal;
            end
         end
         st_grant_ack:
         begin
            // Core stops only once the acknowledge is on the bus
            s_next.core_en_reg = 1'h0; // [R7]
            s_next.fsm_reg = st_grant;
         end
         st_grant:
         begin
            s_next.snoop_ack_reg = snoop_req; // [R8]
            s_next.intr_ack_reg = intr_req; // [R8]
            // Halt release beats sleep in the same cycle
            if (halt_n_sync)
            begin
               s_next.core_en_reg = 1'h1; // [R9]
               s_next.fsm_reg = st_normal;
            end
            else if (!sleep_n_sync)
            begin
               s_next.bus_en_reg = 1'h0; // [R11]
               s_next.lic_en_reg = 1'h0;
               s_next.fsm_reg = st_sleep;
            end
         end
         st_sleep:
         begin
            // Snoops and interrupts dropped here by design
            if (sleep_n_sync)
            begin
               s_next.bus_en_reg = 1'h1; // [R11] [R12]
               s_next.lic_en_reg = 1'h1;
               s_next.fsm_reg = st_grant;
            end
         end
         default:
         begin
            s_next.fsm_reg = st_normal;
         end
      endcase
      // Reset last so it overrides every state
      if (!rst_n)
      begin
         s_next.fsm_reg = st_normal; // [R14]
         s_next.cnt_reg = `CNT_ZERO;
         s_next.in_reset_reg = 1'h1;
         s_next.tri_reg = 1'h0;
         s_next.save_reg = 1'h0;
         s_next.mode_reg = 1'h0;
         s_next.smi_ack_reg = 1'h0;
         s_next.fetch_reg = 1'h0;
         s_next.grant_ack_reg = 1'h0;
         s_next.core_en_reg = 1'h1;
         s_next.bus_en_reg = 1'h1; // [R10]
         s_next.lic_en_reg = 1'h1;
         s_next.snoop_ack_reg = 1'h0;
         s_next.intr_ack_reg = 1'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock)
   begin
      s_reg <= s_next;
   end
   ////////////////////////////////////////////////////////////////////////
   // Outputs come straight from registers, no glue after them
   assign save_state = s_reg.save_reg;
   assign sys_mgmt_mode = s_reg.mode_reg;
   assign smi_ack_cycle = s_reg.smi_ack_reg;
   assign handler_fetch = s_reg.fetch_reg;
   assign grant_ack_cycle = s_reg.grant_ack_reg;
   assign core_clk_en = s_reg.core_en_reg;
   assign bus_clk_en = s_reg.bus_en_reg;
   assign local_interrupt_ctrl_clk_en = s_reg.lic_en_reg;
   assign snoop_ack = s_reg.snoop_ack_reg;
   assign intr_ack = s_reg.intr_ack_reg;
   assign outputs_tristate = s_reg.tri_reg;
endmodule

//--- rtl/pm_ctrl_defines.svh
// Timing counts and reset values for the power management sequencer.
// Assumes a single 20 MHz bus clock; included by its bare name.
`ifndef PM_CTRL_DEFINES_SVH
`define PM_CTRL_DEFINES_SVH
`define SYNC_STAGES 2
`define SAVE_CYCLES 4'h4
`define CNT_ZERO 4'h0
`endif

//--- rtl/pm_ctrl_pkg.sv
// Types shared by the power management sequencer files.
// Assumes the defines header is compiled alongside.
package pm_ctrl_pkg;
   typedef enum logic [2:0] {
      st_normal,
      st_save,
      st_smm_ack,
      st_smm_run,
      st_grant_ack,
      st_grant,
      st_sleep
   } pm_state_t;
endpackage

//--- rtl/sync_bit.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input has no relation to clock.
`timescale 1ns/1ns
module sync_bit
(
   input wire logic clock,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed
   {
      logic meta_reg;
      logic out_reg;
   } sync_st_t;
   sync_st_t state_reg;
   sync_st_t state_next;
   // First flop is read only by the second
   // No reset: the pin level must carry across reset release
   always_comb
   begin
      state_next.meta_reg = async_in;
      state_next.out_reg = state_reg.meta_reg;
   end
   always_ff @(posedge clock)
   begin
      state_reg <= state_next;
   end
   assign sync_out = state_reg.out_reg;
endmodule
